// file: pwmas_ctrl.sv
`timescale 1ns/100ps
`include "pwmas_map.svh"

// How it works
// - shutdown event sets status flag; enabled outputs then held in shutdown states
// - ext pin low causes shutdown only when its enable bit is set
// - port-B pin 4 low causes shutdown only when its enable bit is set
// - pair A/C shutdown: pin A 00 low, 01 high, 1x tri-state; pin C always tri-state
// - pair B/D shutdown: pin B 00 low, 01 high, 1x tri-state; pin D always tri-state
// - shutdown sources are levels; shutdown lasts while source level active
// - software writes to status flag ignored while shutdown condition active
// - after restart, outputs resume only at start of next period
// - auto-restart: flag held during condition, then hardware clears it
// - dead-band delay applied only to inactive-to-active transitions
// - seven-bit delay counts instruction cycles of four clocks each
// - unused shutdown control bit ignores writes, reads zero
// - software setting status flag starts a shutdown
// - shutdown reaches pins without waiting on the pwm timebase
// - new period begins on increment after timer matches period limit
module pwmas_ctrl #(
   parameter int ADDR_W = 12,
   parameter int DLY_W  = 7
) (
   input  wire logic              MCLK,
   input  wire logic              RESETN,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [ADDR_W-1:0] PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   input  wire logic              EXT_INTERRUPT_PIN,
   input  wire logic              PORTB_PIN4,
   output logic                   PWM_OUT_A,
   output logic                   PWM_OE_A,
   output logic                   PWM_OUT_B,
   output logic                   PWM_OE_B,
   output logic                   PWM_OUT_C,
   output logic                   PWM_OE_C,
   output logic                   PWM_OUT_D,
   output logic                   PWM_OE_D
);

   if (ADDR_W < 5 || DLY_W != 7) begin : g_chk
      $error("ADDR_W must be at least 5 and DLY_W must be 7");
   end

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESETN);

   pwmas_pkg::pwmas_byte_t sdc_reg, rdc_reg, ccp_reg, dutyl_reg, dutyh_reg, prd_reg, tmr_reg;
   logic [1:0]       dlat_reg;
   logic [1:0]       q_reg;
   logic             ext_s1_reg, ext_s2_reg, pb4_s1_reg, pb4_s2_reg;
   logic             hold_reg, pwm_raw_reg, pready_reg, slverr_reg;
   logic [31:0]      prdata_reg;
   logic             status_next, hold_next;
   logic             cond, tick, wrap, pwm_en, half, access, commit, wr_sdc, sw_set, sw_clr;
   logic [DLY_W-1:0] dly;
   logic             db_a, db_b;
   logic [1:0]       drv_a, drv_b, drv_c, drv_d;
   logic [31:0]      rd_mux;

   // ==========================================
   // functions
   function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [11:0] off);
      addr_is = (a == ADDR_W'(off));
   endfunction : addr_is

   // returns {oe, out}; shutdown state replaces normal drive
   function automatic logic [1:0] pin_drive(input logic [1:0] ss, input logic en,
                                            input logic sd, input logic val);
      if (!en) begin
         pin_drive = 2'b00;
      end else if (sd) begin
         pin_drive = ss[1] ? 2'b00 : {1'b1, ss[0]};
      end else begin
         pin_drive = {1'b1, val};
      end
   endfunction : pin_drive

   // ==========================================
   // pin synchronisers
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         ext_s1_reg <= 1'b1;
         ext_s2_reg <= 1'b1;
         pb4_s1_reg <= 1'b1;
         pb4_s2_reg <= 1'b1;
      end else begin
         ext_s1_reg <= EXT_INTERRUPT_PIN;
         ext_s2_reg <= ext_s1_reg;
         pb4_s1_reg <= PORTB_PIN4;
         pb4_s2_reg <= pb4_s1_reg;
      end
   end

   // ==========================================
   // decode
   // ext pin gated by enable
   assign cond   = (sdc_reg[`PWMAS_SDC_EXTEN] && !ext_s2_reg) ||
                   (sdc_reg[`PWMAS_SDC_PB4EN] && !pb4_s2_reg);
   assign pwm_en = (ccp_reg[`PWMAS_CCP_MD_HI:`PWMAS_CCP_MD_LO] == `PWMAS_CCP_PWM);
   assign half   = (ccp_reg[`PWMAS_CCP_OM_HI:`PWMAS_CCP_OM_LO] == `PWMAS_CCP_HALF);
   assign tick   = pwm_en && (q_reg == `PWMAS_TCY_LAST);
   assign wrap   = tick && (tmr_reg == prd_reg);
   assign access = PSEL && PENABLE && !pready_reg;
   assign commit = PSEL && PENABLE && pready_reg && PWRITE && !slverr_reg;
   assign wr_sdc = commit && addr_is(PADDR, `PWMAS_OFF_SDC);
   assign sw_set = wr_sdc && PWDATA[`PWMAS_SDC_STATUS];
   assign sw_clr = wr_sdc && !PWDATA[`PWMAS_SDC_STATUS];

   // ==========================================
   // status flag
   always_comb begin
      status_next = sdc_reg[`PWMAS_SDC_STATUS];
      if (cond) begin
         status_next = 1'b1;
      end else if (sw_set) begin
         status_next = 1'b1;
      end else if (sw_clr) begin
         status_next = 1'b0;
      end else if (rdc_reg[`PWMAS_RDC_ARST]) begin
         status_next = 1'b0;
      end
   end

   always_comb begin
      hold_next = hold_reg;
      if (status_next) begin
         hold_next = 1'b1;
      end else if (wrap || !pwm_en) begin
         hold_next = 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         hold_reg <= 1'b0;
      end else begin
         hold_reg <= hold_next;
      end
   end

   // ==========================================
   // registers
   // unused bit never stored
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         sdc_reg   <= `PWMAS_RST_SDC;
         rdc_reg   <= `PWMAS_RST_RDC;
         ccp_reg   <= `PWMAS_RST_CCP;
         dutyl_reg <= `PWMAS_RST_TMR;
         prd_reg   <= `PWMAS_RST_PRD;
      end else begin
         sdc_reg[`PWMAS_SDC_STATUS] <= status_next;
         if (wr_sdc) begin
            sdc_reg[6:0] <= PWDATA[6:0] & 7'(`PWMAS_SDC_WMASK);
         end
         if (commit && addr_is(PADDR, `PWMAS_OFF_RDC)) begin
            rdc_reg <= PWDATA[7:0];
         end
         if (commit && addr_is(PADDR, `PWMAS_OFF_CCP)) begin
            ccp_reg <= PWDATA[7:0];
         end
         if (commit && addr_is(PADDR, `PWMAS_OFF_DUTYL)) begin
            dutyl_reg <= PWDATA[7:0];
         end
         if (commit && addr_is(PADDR, `PWMAS_OFF_PRD)) begin
            prd_reg <= PWDATA[7:0];
         end
      end
   end

   // ==========================================
   // timebase
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         q_reg       <= 2'h0;
         tmr_reg     <= `PWMAS_RST_TMR;
         dutyh_reg   <= `PWMAS_RST_TMR;
         dlat_reg    <= 2'h0;
         pwm_raw_reg <= 1'b0;
      end else begin
         q_reg <= q_reg + 2'h1;
         if (commit && addr_is(PADDR, `PWMAS_OFF_TMR)) begin
            tmr_reg <= PWDATA[7:0];
         end else if (wrap) begin
            tmr_reg <= `PWMAS_RST_TMR;
         end else if (tick) begin
            tmr_reg <= tmr_reg + 8'h01;
         end
         if (wrap) begin
            dutyh_reg   <= dutyl_reg;
            dlat_reg    <= ccp_reg[`PWMAS_CCP_DC_HI:`PWMAS_CCP_DC_LO];
            pwm_raw_reg <= ({dutyl_reg, ccp_reg[`PWMAS_CCP_DC_HI:`PWMAS_CCP_DC_LO]} != 10'h000);
         end else if (!pwm_en || {tmr_reg, q_reg} == {dutyh_reg, dlat_reg}) begin
            pwm_raw_reg <= 1'b0;
         end
      end
   end

   // ==========================================
   // dead-band
   // delay only in half-bridge
   assign dly = half ? rdc_reg[`PWMAS_RDC_DLY_HI:`PWMAS_RDC_DLY_LO] : '0;

   pwmas_deadband #(.DLY_W(DLY_W)) u_db_a (
      .clk       (MCLK),
      .rst_n     (RESETN),
      .tick      (q_reg == `PWMAS_TCY_LAST),
      .level_in  (pwm_raw_reg),
      .delay_cnt (dly),
      .level_out (db_a)
   );

   pwmas_deadband #(.DLY_W(DLY_W)) u_db_b (
      .clk       (MCLK),
      .rst_n     (RESETN),
      .tick      (q_reg == `PWMAS_TCY_LAST),
      .level_in  (half && pwm_en && !pwm_raw_reg),
      .delay_cnt (dly),
      .level_out (db_b)
   );

   // ==========================================
   // pin drivers
   // pair a/c and b/d states
   assign drv_a = pin_drive(sdc_reg[`PWMAS_SDC_AC_HI:`PWMAS_SDC_AC_LO], pwm_en, hold_next, db_a);
   assign drv_b = pin_drive(sdc_reg[`PWMAS_SDC_BD_HI:`PWMAS_SDC_BD_LO], pwm_en && half, hold_next, db_b);
   assign drv_c = pin_drive(sdc_reg[`PWMAS_SDC_AC_HI:`PWMAS_SDC_AC_LO], 1'b0, hold_next, 1'b0);
   assign drv_d = pin_drive(sdc_reg[`PWMAS_SDC_BD_HI:`PWMAS_SDC_BD_LO], 1'b0, hold_next, 1'b0);

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         {PWM_OE_A, PWM_OUT_A} <= 2'b00;
         {PWM_OE_B, PWM_OUT_B} <= 2'b00;
         {PWM_OE_C, PWM_OUT_C} <= 2'b00;
         {PWM_OE_D, PWM_OUT_D} <= 2'b00;
      end else begin
         {PWM_OE_A, PWM_OUT_A} <= drv_a;
         {PWM_OE_B, PWM_OUT_B} <= drv_b;
         {PWM_OE_C, PWM_OUT_C} <= drv_c;
         {PWM_OE_D, PWM_OUT_D} <= drv_d;
      end
   end

   // ==========================================
   // apb slave
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (addr_is(PADDR, `PWMAS_OFF_SDC)) begin
         rd_mux[7:0] = sdc_reg;
      end else if (addr_is(PADDR, `PWMAS_OFF_RDC)) begin
         rd_mux[7:0] = rdc_reg;
      end else if (addr_is(PADDR, `PWMAS_OFF_CCP)) begin
         rd_mux[7:0] = ccp_reg;
      end else if (addr_is(PADDR, `PWMAS_OFF_DUTYL)) begin
         rd_mux[7:0] = dutyl_reg;
      end else if (addr_is(PADDR, `PWMAS_OFF_DUTYH)) begin
         rd_mux[7:0] = dutyh_reg;
      end else if (addr_is(PADDR, `PWMAS_OFF_PRD)) begin
         rd_mux[7:0] = prd_reg;
      end else if (addr_is(PADDR, `PWMAS_OFF_TMR)) begin
         rd_mux[7:0] = tmr_reg;
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         pready_reg <= 1'b0;
         slverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= access;
         if (access) begin
            slverr_reg <= !(addr_is(PADDR, `PWMAS_OFF_SDC) || addr_is(PADDR, `PWMAS_OFF_RDC) ||
                            addr_is(PADDR, `PWMAS_OFF_CCP) || addr_is(PADDR, `PWMAS_OFF_DUTYL) ||
                            addr_is(PADDR, `PWMAS_OFF_DUTYH) || addr_is(PADDR, `PWMAS_OFF_PRD) ||
                            addr_is(PADDR, `PWMAS_OFF_TMR));
            prdata_reg <= PWRITE ? 32'h0000_0000 : rd_mux;
         end else begin
            slverr_reg <= 1'b0;
         end
      end
   end

   assign PREADY  = pready_reg;
   assign PSLVERR = slverr_reg;
   assign PRDATA  = prdata_reg;

   // ==========================================
   // checks
   sequence s_src_active;
      cond ##1 cond;
   endsequence

   sequence s_auto_clear;
      sdc_reg[`PWMAS_SDC_STATUS] && !cond && rdc_reg[`PWMAS_RDC_ARST] && !sw_set;
   endsequence

   AST_SET_ON_EVENT: assert property (cond |=> sdc_reg[`PWMAS_SDC_STATUS] && hold_reg)
      else $error("shutdown event did not set status and hold");

   AST_EXT_PIN: assert property ((sdc_reg[`PWMAS_SDC_EXTEN] && !ext_s2_reg) |=> sdc_reg[`PWMAS_SDC_STATUS])
      else $error("ext pin low did not cause shutdown");

   AST_NO_SRC: assert property ((!sdc_reg[`PWMAS_SDC_EXTEN] && !sdc_reg[`PWMAS_SDC_PB4EN] &&
      !sdc_reg[`PWMAS_SDC_STATUS] && !sw_set) |=> !sdc_reg[`PWMAS_SDC_STATUS])
      else $error("disabled source caused shutdown");

   AST_PIN4: assert property ((sdc_reg[`PWMAS_SDC_PB4EN] && !pb4_s2_reg) |=> sdc_reg[`PWMAS_SDC_STATUS])
      else $error("pin 4 low did not cause shutdown");

   AST_AC_STATE: assert property ((hold_next && pwm_en && !sdc_reg[`PWMAS_SDC_AC_HI])
      |=> PWM_OE_A && PWM_OUT_A == $past(sdc_reg[`PWMAS_SDC_AC_LO]))
      else $error("pair a/c shutdown level wrong");

   AST_BD_TRI: assert property ((hold_next && sdc_reg[`PWMAS_SDC_BD_HI]) |=> !PWM_OE_B)
      else $error("pair b/d not tri-stated");

   AST_LEVEL_HOLD: assert property (s_src_active |=> sdc_reg[`PWMAS_SDC_STATUS] && hold_reg)
      else $error("shutdown released while source active");

   AST_WR_IGNORED: assert property ((cond && sw_clr) |=> sdc_reg[`PWMAS_SDC_STATUS])
      else $error("status cleared while condition active");

   AST_RESUME_AT_PERIOD: assert property ($fell(hold_reg) |-> $past(wrap) || !$past(pwm_en))
      else $error("outputs resumed outside period start");

   AST_AUTO_CLEAR: assert property (s_auto_clear |=> !sdc_reg[`PWMAS_SDC_STATUS])
      else $error("auto-restart did not clear status");

   AST_MANUAL_KEEP: assert property ((sdc_reg[`PWMAS_SDC_STATUS] && !rdc_reg[`PWMAS_RDC_ARST] && !sw_clr)
      |=> sdc_reg[`PWMAS_SDC_STATUS])
      else $error("status cleared without software");

   AST_UNUSED_ZERO: assert property (!sdc_reg[`PWMAS_SDC_UNUSED])
      else $error("unused bit not zero");

   AST_SW_START: assert property (sw_set |=> sdc_reg[`PWMAS_SDC_STATUS] && hold_reg)
      else $error("software set did not start shutdown");

   AST_WRAP_CLEARS: assert property ((wrap && !commit) |=> tmr_reg == `PWMAS_RST_TMR)
      else $error("timer did not wrap after match");

   AST_NO_OVERLAP: assert property (!(PWM_OE_A && PWM_OUT_A && PWM_OE_B && PWM_OUT_B && !hold_reg))
      else $error("both half-bridge outputs active");

endmodule : pwmas_ctrl

// file: pwmas_map.svh
`ifndef PWMAS_MAP_SVH
`define PWMAS_MAP_SVH

// ==========================================
// register byte offsets
`define PWMAS_OFF_SDC    12'h000
`define PWMAS_OFF_RDC    12'h004
`define PWMAS_OFF_CCP    12'h008
`define PWMAS_OFF_DUTYL  12'h00c
`define PWMAS_OFF_DUTYH  12'h010
`define PWMAS_OFF_PRD    12'h014
`define PWMAS_OFF_TMR    12'h018

// ==========================================
// shutdown control fields
`define PWMAS_SDC_STATUS 7
`define PWMAS_SDC_EXTEN  6
`define PWMAS_SDC_PB4EN  4
`define PWMAS_SDC_UNUSED 5
`define PWMAS_SDC_AC_HI  3
`define PWMAS_SDC_AC_LO  2
`define PWMAS_SDC_BD_HI  1
`define PWMAS_SDC_BD_LO  0
`define PWMAS_SDC_WMASK  8'h5f

// ==========================================
// restart and dead-band fields
`define PWMAS_RDC_ARST   7
`define PWMAS_RDC_DLY_HI 6
`define PWMAS_RDC_DLY_LO 0

// ==========================================
// capture compare pwm control fields
`define PWMAS_CCP_OM_HI  7
`define PWMAS_CCP_OM_LO  6
`define PWMAS_CCP_DC_HI  5
`define PWMAS_CCP_DC_LO  4
`define PWMAS_CCP_MD_HI  3
`define PWMAS_CCP_MD_LO  2
`define PWMAS_CCP_PWM    2'b11
`define PWMAS_CCP_HALF   2'b10

// ==========================================
// reset values and timing
`define PWMAS_RST_SDC    8'h00
`define PWMAS_RST_RDC    8'h00
`define PWMAS_RST_CCP    8'h00
`define PWMAS_RST_PRD    8'hff
`define PWMAS_RST_TMR    8'h00
`define PWMAS_TCY_LAST   2'h3

`endif

// file: pwmas_pkg.sv
package pwmas_pkg;

   // ==========================================
   // dead-band delay states
   typedef enum logic [1:0] {
      PWMAS_DB_IDLE   = 2'b00,
      PWMAS_DB_WAIT   = 2'b01,
      PWMAS_DB_ACTIVE = 2'b10
   } pwmas_db_e;

   typedef logic [7:0] pwmas_byte_t;

endpackage : pwmas_pkg

// file: pwmas_deadband.sv
`timescale 1ns/100ps
module pwmas_deadband #(
   parameter int DLY_W = 7
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             tick,
   input  wire logic             level_in,
   input  wire logic [DLY_W-1:0] delay_cnt,
   output logic                  level_out
);

   pwmas_pkg::pwmas_db_e state_reg;
   logic [DLY_W-1:0]     cnt_reg;

   if (DLY_W < 1) begin : g_chk
      $error("DLY_W must be at least 1");
   end

   // ==========================================
   // rising edge delay
   // delay rising only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= pwmas_pkg::PWMAS_DB_IDLE;
         cnt_reg   <= '0;
      end else begin
         case (state_reg)
            pwmas_pkg::PWMAS_DB_IDLE: begin
               if (level_in) begin
                  cnt_reg   <= delay_cnt;
                  state_reg <= (delay_cnt == '0) ? pwmas_pkg::PWMAS_DB_ACTIVE : pwmas_pkg::PWMAS_DB_WAIT;
               end
            end
            pwmas_pkg::PWMAS_DB_WAIT: begin
               if (!level_in) begin
                  state_reg <= pwmas_pkg::PWMAS_DB_IDLE;
               end else if (tick) begin
                  cnt_reg <= cnt_reg - 1'b1;
                  if (cnt_reg <= 1) begin
                     state_reg <= pwmas_pkg::PWMAS_DB_ACTIVE;
                  end
               end
            end
            pwmas_pkg::PWMAS_DB_ACTIVE: begin
               if (!level_in) begin
                  state_reg <= pwmas_pkg::PWMAS_DB_IDLE;
               end
            end
            default: begin
               state_reg <= pwmas_pkg::PWMAS_DB_IDLE;
            end
         endcase
      end
   end

   // falling edge passes at once
   assign level_out = level_in && (state_reg == pwmas_pkg::PWMAS_DB_ACTIVE);

   // ==========================================
   // checks
   AST_DB_NO_EARLY: assert property (@(posedge clk) disable iff (!rst_n)
      (state_reg == pwmas_pkg::PWMAS_DB_IDLE && level_in && delay_cnt != '0) |=> !level_out)
      else $error("dead-band output rose without delay");

   AST_DB_FALL_FAST: assert property (@(posedge clk) disable iff (!rst_n)
      (state_reg == pwmas_pkg::PWMAS_DB_ACTIVE && !level_in) |=> (state_reg == pwmas_pkg::PWMAS_DB_IDLE))
      else $error("dead-band falling edge was delayed");

endmodule : pwmas_deadband

// file: pwmas_bridge_model.sv
`timescale 1ns/100ps
// ==========================================
// fault sources and half-bridge switch watch
module pwmas_bridge_model (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ext_low,
   input  wire logic pb4_low,
   input  wire logic meas_en,
   input  wire logic act_a,
   input  wire logic act_b,
   output logic      ext_pin,
   output logic      pb4_pin,
   output int        shoot_cnt,
   output int        gap_min,
   output int        gap_max
);
   logic a_q;
   logic b_q;
   int   cnt;
   assign ext_pin = ext_low ? 1'b0 : 1'b1;
   assign pb4_pin = pb4_low ? 1'b0 : 1'b1;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         a_q       <= 1'b0;
         b_q       <= 1'b0;
         cnt       <= 0;
         shoot_cnt <= 0;
         gap_min   <= 1000;
         gap_max   <= 0;
      end else begin
         a_q <= act_a;
         b_q <= act_b;
         cnt <= ((a_q && !act_a) || (b_q && !act_b)) ? 0 : cnt + 1;
         if (meas_en && act_a && act_b) begin
            shoot_cnt <= shoot_cnt + 1;
         end
         if (meas_en && ((act_a && !a_q) || (act_b && !b_q))) begin
            gap_min <= (cnt + 1 < gap_min) ? cnt + 1 : gap_min;
            gap_max <= (cnt + 1 > gap_max) ? cnt + 1 : gap_max;
         end
      end
   end
endmodule : pwmas_bridge_model

// file: pwm_auto_shutdown_deadband_test.sv
`timescale 1ns/100ps
`include "pwmas_map.svh"
module pwm_auto_shutdown_deadband_test;
   localparam int DLY = 2;
   logic        MCLK = 1'b0;
   logic        RESETN = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        ext_low = 1'b0;
   logic        pb4_low = 1'b0;
   logic        meas_en = 1'b0;
   logic [31:0] prdata;
   logic        pready, pslverr, ext_pin, pb4_pin;
   logic        out_a, oe_a, out_b, oe_b, out_c, oe_c, out_d, oe_d;
   int          shoot_cnt, gap_min, gap_max;
   int          miscompares = 0;
   int          tests_run = 0;
   int          cyc = 0;
   logic [31:0] rd;
   logic        err;
   logic [1:0]  ac;
   logic [1:0]  bd;

   always #50 MCLK = ~MCLK;

   pwmas_ctrl uut (.MCLK(MCLK), .RESETN(RESETN), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .EXT_INTERRUPT_PIN(ext_pin), .PORTB_PIN4(pb4_pin), .PWM_OUT_A(out_a), .PWM_OE_A(oe_a),
      .PWM_OUT_B(out_b), .PWM_OE_B(oe_b), .PWM_OUT_C(out_c), .PWM_OE_C(oe_c),
      .PWM_OUT_D(out_d), .PWM_OE_D(oe_d));

   pwmas_bridge_model bridge (.clk(MCLK), .rst_n(RESETN), .ext_low(ext_low), .pb4_low(pb4_low),
      .meas_en(meas_en), .act_a(oe_a & out_a), .act_b(oe_b & out_b), .ext_pin(ext_pin),
      .pb4_pin(pb4_pin), .shoot_cnt(shoot_cnt), .gap_min(gap_min), .gap_max(gap_max));

   // ==========================================
   // access and compare tasks
   task finish_test;
      $display("TB: miscompares=%0d tests_run=%0d", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge MCLK);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge MCLK);
      penable <= 1'b1;
      do @(posedge MCLK); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   task rdchk(input logic [11:0] a, input logic [7:0] exp, input logic e);
      apb(1'b0, a, 32'h0);
      check(rd, {24'h0, exp});
      check({31'h0, err}, {31'h0, e});
   endtask : rdchk

   task pins(input logic [1:0] oe, input logic [1:0] val);
      check({28'h0, oe_c, oe_d, oe_a, oe_b}, {28'h0, 2'b00, oe});
      check({30'h0, out_a & oe[1], out_b & oe[0]}, {30'h0, val & oe});
      check({30'h0, out_c, out_d}, 32'h0);
   endtask : pins

   always @(posedge MCLK) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         miscompares++;
         $display("BAD %0t run did not complete", $time);
         finish_test;
      end
   end

   // ==========================================
   // main sequence
   initial begin
      repeat (16) @(posedge MCLK);
      RESETN <= 1'b1;
      rdchk(`PWMAS_OFF_SDC, 8'h00, 1'b0);
      rdchk(`PWMAS_OFF_RDC, 8'h00, 1'b0);
      rdchk(`PWMAS_OFF_CCP, 8'h00, 1'b0);
      rdchk(`PWMAS_OFF_PRD, 8'hff, 1'b0);
      rdchk(`PWMAS_OFF_TMR, 8'h00, 1'b0);
      rdchk(12'h01c, 8'h00, 1'b1);
      apb(1'b1, `PWMAS_OFF_DUTYH, 32'hff);
      rdchk(`PWMAS_OFF_DUTYH, 8'h00, 1'b0);
      apb(1'b1, `PWMAS_OFF_PRD, 32'h07);
      apb(1'b1, `PWMAS_OFF_DUTYL, 32'h04);
      apb(1'b1, `PWMAS_OFF_RDC, DLY);
      apb(1'b1, `PWMAS_OFF_CCP, 32'h8c);
      for (int k = 0; k < 3; k++) begin
         ac = 2'(k);
         bd = 2'(2 - k);
         apb(1'b1, `PWMAS_OFF_SDC, {24'h0, 4'ha, ac, bd});
         rdchk(`PWMAS_OFF_SDC, {4'h8, ac, bd}, 1'b0);
         pins({~ac[1], ~bd[1]}, {ac[0], bd[0]});
         apb(1'b1, `PWMAS_OFF_SDC, 32'h00);
         rdchk(`PWMAS_OFF_SDC, 8'h00, 1'b0);
      end
      repeat (64) @(posedge MCLK);
      meas_en <= 1'b1;
      repeat (200) @(posedge MCLK);
      meas_en <= 1'b0;
      check(shoot_cnt, 0);
      check({31'h0, gap_min >= (DLY - 1) * 4 + 1}, 32'h1);
      check({31'h0, gap_max <= DLY * 4 && gap_min <= gap_max}, 32'h1);
      apb(1'b1, `PWMAS_OFF_SDC, 32'h44);
      ext_low <= 1'b1;
      repeat (8) @(posedge MCLK);
      rdchk(`PWMAS_OFF_SDC, 8'hc4, 1'b0);
      pins(2'b11, 2'b10);
      apb(1'b1, `PWMAS_OFF_SDC, 32'h44);
      rdchk(`PWMAS_OFF_SDC, 8'hc4, 1'b0);
      ext_low <= 1'b0;
      repeat (8) @(posedge MCLK);
      rdchk(`PWMAS_OFF_SDC, 8'hc4, 1'b0);
      apb(1'b1, `PWMAS_OFF_SDC, 32'h44);
      rdchk(`PWMAS_OFF_SDC, 8'h44, 1'b0);
      apb(1'b1, `PWMAS_OFF_SDC, 32'h0a);
      ext_low <= 1'b1;
      pb4_low <= 1'b1;
      repeat (8) @(posedge MCLK);
      rdchk(`PWMAS_OFF_SDC, 8'h0a, 1'b0);
      apb(1'b1, `PWMAS_OFF_SDC, 32'h1a);
      repeat (8) @(posedge MCLK);
      rdchk(`PWMAS_OFF_SDC, 8'h9a, 1'b0);
      pins(2'b00, 2'b00);
      apb(1'b1, `PWMAS_OFF_RDC, 32'h80 | DLY);
      repeat (100) @(posedge MCLK);
      rdchk(`PWMAS_OFF_SDC, 8'h9a, 1'b0);
      pins(2'b00, 2'b00);
      pb4_low <= 1'b0;
      ext_low <= 1'b0;
      repeat (8) @(posedge MCLK);
      rdchk(`PWMAS_OFF_SDC, 8'h1a, 1'b0);
      repeat (40) @(posedge MCLK);
      check({30'h0, oe_a, oe_b}, 32'h3);
      apb(1'b1, `PWMAS_OFF_CCP, 32'h0c);
      repeat (2) @(posedge MCLK);
      check({30'h0, oe_a, oe_b}, 32'h2);
      finish_test;
   end
endmodule : pwm_auto_shutdown_deadband_test
